// *** design/swpc_core.sv ***
// spi slave front end with watchdog, failsafe and pump control
`timescale 1ns/1ps
//
// Overview of operation
// (RL1) frames are 16 bits, bit 15 shifted first.
// (RL2) clock idles low; input sampled on falling edge, mode cpol0 cpha1.
// (RL3) interface responds only while chip select is low.
// (RL4) input and output shift registers run msb first.
// (RL5) daisy chain: shifted-in bits reappear on serial output.
// (RL6) clock edge count not a multiple of sixteen flags length error.
// (RL7) chip select period without clock edges flags an error.
// (RL8) unused bits must be zero; undefined commands flag an error.
// (RL9) watchdog bit must invert every frame, else toggle error.
// (RL10) no toggle within 25 ms, or 500 ms if selected, flags timeout.
// (RL11) after reset first frame carries watchdog bit 0, then 1.
// (RL12) stuck serial input caught by the toggle check only.
// (RL13) low logic supply blocks all serial interface function.
// (RL14) spi error flag clear means good; normal mode flag one.
// (RL15) any spi error enters failsafe mode at once.
// (RL16) replies lag commands by exactly one frame.
// (RL17) driver enable zero keeps pump and gate drive off.
// (RL18) driver enable one enables pump and full power.
// (RL19) switched pump output on only while its bit is one.
// (RL20) pump failure sets flag and shuts all gate outputs.
// (RL21) outputs off and control refused until supply is good.
// (RL22) pump resumes by itself when overvoltage clears.
// (RL23) frame: address 15..12, watchdog bit 11, data 10..0.
// (RL24) every control bit clears on any reset.
// (RL25) serial output released while chip select is high.
module swpc_core #(
  parameter int WD_SHORT = swpc_pkg::WD_SHORT_CYC,
  parameter int WD_LONG  = swpc_pkg::WD_LONG_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        logic_supply_por_fall,
  input  wire logic        chip_select_n,
  input  wire logic        spi_clk,
  input  wire logic        spi_din,
  input  wire logic        pump_fail_in,
  input  wire logic        pump_low_in,
  input  wire logic        supply_overvoltage,
  input  wire logic [10:0] reply_data,
  output logic             spi_dout,
  output logic             spi_dout_oe_n,
  output logic             driver_power_enable,
  output logic             pump_enable,
  output logic             switched_pump_output,
  output logic             watchdog_period_select,
  output logic             gate_enable,
  output logic             spi_error_flag,
  output logic             normal_mode_flag,
  output logic             pump_fail_flag,
  output logic             pump_low_flag,
  output logic [8:0]       main_status_reg,
  output logic             frame_strobe,
  output logic [15:0]      frame_word
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [1:0] cs_sync;
  logic [1:0] clk_sync;
  logic [1:0] din_sync;
  logic [1:0] por_sync;
  logic [1:0] cpf_sync;
  logic [1:0] cpl_sync;
  logic [1:0] ov_sync;
  logic       cs_q;
  logic       clk_q;

  // two stages per pin, first stage read only by second
  always_ff @(posedge core_clk) begin
    cs_sync  <= {cs_sync[0], chip_select_n};
    clk_sync <= {clk_sync[0], spi_clk};
    din_sync <= {din_sync[0], spi_din};
    por_sync <= {por_sync[0], logic_supply_por_fall};
    cpf_sync <= {cpf_sync[0], pump_fail_in};
    cpl_sync <= {cpl_sync[0], pump_low_in};
    ov_sync  <= {ov_sync[0], supply_overvoltage};
    cs_q     <= cs_sync[1];
    clk_q    <= clk_sync[1];
  end

  // supply low blocks the whole interface
  wire supply_ok = !por_sync[1];                            // RL13 RL21
  wire cs_active = !cs_sync[1] && supply_ok;                // RL3
  wire cs_start  = cs_q && !cs_sync[1] && supply_ok;
  wire cs_end    = !cs_q && cs_sync[1] && supply_ok;
  wire fall_edge = cs_active && clk_q && !clk_sync[1];      // RL2
  wire rise_edge = cs_active && !clk_q && clk_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // frame state
  typedef enum logic [2:0] {
    SWPC_IDLE  = 3'b001,
    SWPC_SHIFT = 3'b010,
    SWPC_CHECK = 3'b100
  } swpc_state_type;

  swpc_state_type state;
  swpc_state_type next_state;
  logic [15:0]    rx_shift;
  logic [15:0]    tx_shift;
  logic [15:0]    reply_word;
  logic [15:0]    last_word;
  logic [3:0]     bit_count;
  logic           any_edge;
  logic           word_done;
  logic           wd_last;
  logic           wd_seen;
  logic           good_toggle;
  logic [2:0]     mode_bits;
  logic           fail_state;
  logic           len_err;
  logic           noclk_err;
  logic           cmd_err;
  logic           tog_err;
  logic           tmo_err;
  logic           wd_expired;

  function automatic logic cmd_undefined(input logic [15:0] w);
    logic [3:0] a;
    a = w[swpc_pkg::ADDR_MSB:swpc_pkg::ADDR_LSB];
    cmd_undefined = (a == swpc_pkg::ADDR_UNUSED_A) || (a == swpc_pkg::ADDR_UNUSED_B) ||
                    ((a == swpc_pkg::ADDR_MODE_CTRL) &&
                     ((w[10:0] & ~swpc_pkg::MODE_USED_MASK) != 11'h000));
  endfunction

  // state sequencing
  always_comb begin
    next_state = state;
    case (state)
      SWPC_IDLE:  if (cs_start) next_state = SWPC_SHIFT;
      SWPC_SHIFT: if (cs_end || !supply_ok) next_state = SWPC_CHECK;
      SWPC_CHECK: next_state = SWPC_IDLE;
      default:    next_state = SWPC_IDLE;
    endcase
  end

  wire last_bit   = fall_edge && (bit_count == 4'hF);
  wire [15:0] rx_next = {rx_shift[14:0], din_sync[1]};    // RL1 RL4
  wire frame_ok   = any_edge && (bit_count == 4'h0) && word_done;
  wire wd_bit     = last_word[swpc_pkg::WD_BIT];          // RL23
  wire expect_wd  = wd_seen ? !wd_last : 1'b0;            // RL11
  wire toggle_bad = wd_bit != expect_wd;                  // RL9 RL12
  wire check_now  = (state == SWPC_CHECK);
  wire err_now    = supply_ok && ((check_now && (!any_edge || !frame_ok ||
                    cmd_undefined(last_word) || toggle_bad)) || wd_expired);

  // shifting and per-frame bookkeeping
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state      <= SWPC_IDLE;
      rx_shift   <= 16'h0000;
      tx_shift   <= 16'h0000;
      last_word  <= 16'h0000;
      bit_count  <= 4'h0;
      any_edge   <= 1'b0;
      word_done  <= 1'b0;
    end else begin
      state <= next_state;
      if (cs_start) begin
        bit_count <= 4'h0;
        any_edge  <= 1'b0;
        word_done <= 1'b0;
        tx_shift  <= reply_word;                          // RL16
      end
      if (fall_edge) begin
        rx_shift  <= rx_next;
        bit_count <= bit_count + 4'h1;                    // RL6
        any_edge  <= 1'b1;
      end
      if (last_bit) begin
        word_done <= 1'b1;
        last_word <= rx_next;
      end
      // output shifts on rising edge; newest input bit follows, 16 bits late
      if (rise_edge && any_edge) begin
        tx_shift <= {tx_shift[14:0], rx_shift[0]};        // RL5
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // error checks, control register, outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst || !supply_ok) begin
      mode_bits   <= swpc_pkg::MODE_RESET;                // RL24 RL17
      fail_state  <= 1'b0;
      wd_last     <= 1'b0;
      wd_seen     <= 1'b0;
      good_toggle <= 1'b0;
      len_err     <= 1'b0;
      noclk_err   <= 1'b0;
      cmd_err     <= 1'b0;
      tog_err     <= 1'b0;
      tmo_err     <= 1'b0;
      reply_word  <= 16'h0000;
    end else begin
      good_toggle <= 1'b0;
      if (wd_expired) tmo_err <= 1'b1;                    // RL10
      if (check_now) begin
        if (!any_edge) noclk_err <= 1'b1;                 // RL7
        else if (!frame_ok) len_err <= 1'b1;              // RL6
        else begin
          wd_seen <= 1'b1;
          wd_last <= wd_bit;
          if (cmd_undefined(last_word)) cmd_err <= 1'b1;  // RL8
          if (toggle_bad) tog_err <= 1'b1;                // RL9
          else good_toggle <= 1'b1;
          if (!fail_state && !cmd_undefined(last_word) && !toggle_bad &&
              last_word[15:12] == swpc_pkg::ADDR_MODE_CTRL) begin
            mode_bits <= last_word[2:0];                  // RL18 RL19
          end
          reply_word <= {last_word[15:11], reply_data};   // RL16
        end
      end
      if (err_now) begin
        fail_state <= 1'b1;                               // RL15
        mode_bits  <= swpc_pkg::MODE_RESET;
      end
    end
  end

  swpc_wd_timer #(
    .SHORT_CYC (WD_SHORT),
    .LONG_CYC  (WD_LONG)
  ) u_wd (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .run      (supply_ok && wd_seen && !fail_state),
    .kick     (good_toggle),
    .long_sel (mode_bits[swpc_pkg::WATCHDOG_PERIOD_SELECT_POS]),
    .expired  (wd_expired)
  );

  wire spi_err = len_err | noclk_err | cmd_err | tog_err | tmo_err;
  wire drv_on  = mode_bits[swpc_pkg::DRIVER_POWER_ENABLE_POS] && supply_ok;
  wire gate_ok = drv_on && !cpf_sync[1] && !ov_sync[1];

  // registered outputs
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      spi_dout               <= 1'b0;
      spi_dout_oe_n          <= 1'b1;
      driver_power_enable    <= 1'b0;
      pump_enable            <= 1'b0;
      switched_pump_output   <= 1'b0;
      watchdog_period_select <= 1'b0;
      gate_enable            <= 1'b0;
      spi_error_flag         <= 1'b0;
      normal_mode_flag       <= 1'b0;
      pump_fail_flag         <= 1'b0;
      pump_low_flag          <= 1'b0;
      main_status_reg        <= 9'h000;
      frame_strobe           <= 1'b0;
      frame_word             <= 16'h0000;
    end else begin
      spi_dout               <= tx_shift[15];               // RL4
      spi_dout_oe_n          <= !cs_active;                 // RL25
      driver_power_enable    <= drv_on;                     // RL17 RL18
      pump_enable            <= drv_on && !ov_sync[1];      // RL22
      switched_pump_output   <= mode_bits[swpc_pkg::PUMP_SWITCH_ENABLE_POS] && supply_ok && !ov_sync[1]; // RL19
      watchdog_period_select <= mode_bits[swpc_pkg::WATCHDOG_PERIOD_SELECT_POS];
      gate_enable            <= gate_ok;                    // RL20
      spi_error_flag         <= spi_err;                    // RL14
      normal_mode_flag       <= supply_ok && !fail_state && !err_now; // RL14
      pump_fail_flag         <= cpf_sync[1];                // RL20
      pump_low_flag          <= cpl_sync[1];
      main_status_reg        <= {tmo_err, tog_err, cmd_err, noclk_err, len_err,
                                 cpl_sync[1], cpf_sync[1], !fail_state, spi_err};
      frame_strobe           <= check_now && frame_ok;
      frame_word             <= last_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_fail_seen;
    err_now ##1 1'b1;
  endsequence

  chk_fail_entry: assert property (@(posedge core_clk) disable iff (sys_rst) // RL15
    err_now |=> fail_state) else $error("failsafe not entered");
  chk_nm_drop: assert property (@(posedge core_clk) disable iff (sys_rst) // RL14
    s_fail_seen |-> !normal_mode_flag) else $error("normal mode flag stayed");
  chk_dout_hiz: assert property (@(posedge core_clk) disable iff (sys_rst) // RL25
    !cs_active |=> spi_dout_oe_n) else $error("output driven while deselected");
  chk_pump_off: assert property (@(posedge core_clk) disable iff (sys_rst) // RL17
    !mode_bits[swpc_pkg::DRIVER_POWER_ENABLE_POS] |=> !pump_enable && !gate_enable)
    else $error("pump on without enable");
  chk_gate_cpf: assert property (@(posedge core_clk) disable iff (sys_rst) // RL20
    cpf_sync[1] |=> !gate_enable && pump_fail_flag) else $error("gates on in pump fail");
  chk_por_block: assert property (@(posedge core_clk) disable iff (sys_rst) // RL21
    !supply_ok |=> !driver_power_enable ##1 mode_bits == swpc_pkg::MODE_RESET)
    else $error("outputs live below supply threshold");
  chk_noclk_err: assert property (@(posedge core_clk) disable iff (sys_rst) // RL7
    check_now && !any_edge && supply_ok |=> noclk_err ##1 spi_error_flag)
    else $error("empty frame not flagged");
  chk_len_err: assert property (@(posedge core_clk) disable iff (sys_rst) // RL6
    check_now && any_edge && !frame_ok && supply_ok |=> len_err)
    else $error("length error missed");
  chk_toggle_err: assert property (@(posedge core_clk) disable iff (sys_rst) // RL9
    check_now && frame_ok && toggle_bad && supply_ok |=> tog_err && fail_state)
    else $error("toggle error missed");
  chk_sw_bit: assert property (@(posedge core_clk) disable iff (sys_rst) // RL19
    switched_pump_output |-> $past(mode_bits[swpc_pkg::PUMP_SWITCH_ENABLE_POS]))
    else $error("switched pump on without bit");
endmodule

// *** design/swpc_pkg.sv ***
// package of constants for the spi watchdog power control block
package swpc_pkg;
  localparam int          FRAME_BITS      = 16;
  localparam int          ADDR_MSB        = 15;
  localparam int          ADDR_LSB        = 12;
  localparam int          WD_BIT          = 11;
  localparam int          CLK_MHZ         = 50;
  localparam int          WD_SHORT_MS     = 25;
  localparam int          WD_LONG_MS      = 500;
  localparam int          WD_SHORT_CYC    = WD_SHORT_MS * CLK_MHZ * 1000;
  localparam int          WD_LONG_CYC     = WD_LONG_MS * CLK_MHZ * 1000;
  localparam logic [3:0]  ADDR_MODE_CTRL  = 4'h1;
  localparam logic [3:0]  ADDR_UNUSED_A   = 4'hB;
  localparam logic [3:0]  ADDR_UNUSED_B   = 4'hD;
  localparam int          DRIVER_POWER_ENABLE_POS      = 0;
  localparam int          PUMP_SWITCH_ENABLE_POS       = 1;
  localparam int          WATCHDOG_PERIOD_SELECT_POS      = 2;
  localparam logic [10:0] MODE_USED_MASK  = 11'h007;
  localparam logic [2:0]  MODE_RESET      = 3'h0;
  localparam int          ST_SPI_ERROR_FLAG_POS     = 0;
  localparam int          ST_NM_POS       = 1;
  localparam int          ST_CPF_POS      = 2;
  localparam int          ST_CPL_POS      = 3;
  localparam int          ST_LEN_POS      = 4;
  localparam int          ST_NOCLK_POS    = 5;
  localparam int          ST_CMD_POS      = 6;
  localparam int          ST_TOG_POS      = 7;
  localparam int          ST_TMO_POS      = 8;
endpackage

// *** design/swpc_wd_timer.sv ***
// watchdog timeout counter with selectable period
`timescale 1ns/1ps
module swpc_wd_timer #(
  parameter int SHORT_CYC = swpc_pkg::WD_SHORT_CYC,
  parameter int LONG_CYC  = swpc_pkg::WD_LONG_CYC
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic run,
  input  wire logic kick,
  input  wire logic long_sel,
  output logic      expired
);
  logic [25:0] count;
  wire  [25:0] limit = long_sel ? LONG_CYC[25:0] : SHORT_CYC[25:0];

  // count while running, restart on each good toggle
  always_ff @(posedge core_clk) begin
    if (sys_rst || !run || kick) begin
      count   <= 26'h0000000;
      expired <= 1'b0;
    end else if (count >= limit - 26'h0000001) begin
      expired <= 1'b1; // RL10
    end else begin
      count <= count + 26'h0000001;
    end
  end
endmodule

// *** test/swpc_host_model.sv ***
// host side spi master model, mode cpol0 cpha1, 160 ns serial clock
`timescale 1ns/1ps
module swpc_host_model (
  input  wire logic core_clk,
  input  wire logic so_line,
  output logic      chip_select_n,
  output logic      spi_clk,
  output logic      spi_din
);
  // idle pins: select high, clock low
  initial begin
    chip_select_n = 1'b1;
    spi_clk = 1'b0;
    spi_din = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // one frame of n bits, msb first; reply sampled late in each low phase
  task automatic xfer(input logic [31:0] w, input int n, output logic [31:0] rx);
    rx = '0;
    @(posedge core_clk);
    chip_select_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = n - 1; i >= 0; i--) begin
      spi_clk <= 1'b1;
      spi_din <= w[i];
      repeat (4) @(posedge core_clk);
      spi_clk <= 1'b0;
      repeat (3) @(posedge core_clk);
      @(negedge core_clk) rx = {rx[30:0], so_line};
      @(posedge core_clk);
    end
    chip_select_n <= 1'b1;
    spi_din <= ~spi_din; // released line must not hold its last bit
    repeat (12) @(posedge core_clk);
  endtask
endmodule

// *** test/test_spi_watchdog_power_control.sv ***
// self-checking bench for the spi watchdog power control block
`timescale 1ns/1ps
module test_spi_watchdog_power_control;
  logic        core_clk;
  logic        sys_rst;
  logic        logic_supply_por_fall;
  logic        pump_fail_in;
  logic        pump_low_in;
  logic        supply_overvoltage;
  logic [10:0] reply_data;
  logic        chip_select_n, spi_clk, spi_din, spi_dout, spi_dout_oe_n;
  logic        driver_power_enable, pump_enable, switched_pump_output;
  logic        watchdog_period_select, gate_enable, spi_error_flag;
  logic        normal_mode_flag, pump_fail_flag, pump_low_flag, frame_strobe;
  logic [8:0]  main_status_reg;
  logic [15:0] frame_word;
  logic [31:0] rx;
  wire         so_line;
  int          errors;
  int          check_count;
  int          strobes = 0;

  // status bit expected for each error scenario
  function automatic int cause_of(input int k);
    case (k)
      0:       cause_of = swpc_pkg::ST_LEN_POS;
      1:       cause_of = swpc_pkg::ST_NOCLK_POS;
      2, 3:    cause_of = swpc_pkg::ST_CMD_POS;
      5:       cause_of = swpc_pkg::ST_TMO_POS;
      default: cause_of = swpc_pkg::ST_TOG_POS;
    endcase
  endfunction

  // released serial output floats
  assign so_line = spi_dout_oe_n ? 1'bz : spi_dout;

  swpc_core #(.WD_SHORT(2000), .WD_LONG(4000)) DUT (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .logic_supply_por_fall(logic_supply_por_fall), .chip_select_n(chip_select_n),
    .spi_clk(spi_clk), .spi_din(spi_din), .pump_fail_in(pump_fail_in),
    .pump_low_in(pump_low_in), .supply_overvoltage(supply_overvoltage),
    .reply_data(reply_data), .spi_dout(spi_dout), .spi_dout_oe_n(spi_dout_oe_n),
    .driver_power_enable(driver_power_enable), .pump_enable(pump_enable),
    .switched_pump_output(switched_pump_output),
    .watchdog_period_select(watchdog_period_select), .gate_enable(gate_enable),
    .spi_error_flag(spi_error_flag), .normal_mode_flag(normal_mode_flag),
    .pump_fail_flag(pump_fail_flag), .pump_low_flag(pump_low_flag),
    .main_status_reg(main_status_reg), .frame_strobe(frame_strobe),
    .frame_word(frame_word));

  swpc_host_model host (
    .core_clk(core_clk), .so_line(so_line), .chip_select_n(chip_select_n),
    .spi_clk(spi_clk), .spi_din(spi_din));

  ////////////////////////////////////////////////////////////////////////////////
  // compare helpers and verdict
  task automatic cmp1(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", name, exp, got);
    end
  endtask
  task automatic cmp16(input string name, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic summarize();
    if (errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // clock, reset, frame and wait helpers
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    sys_rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    tick(4);
  endtask
  task automatic send(input logic [31:0] w, input int n);
    host.xfer(w, n, rx);
    #1;
  endtask
  task automatic pin(input int which, input logic v);
    @(posedge core_clk);
    case (which)
      0: pump_fail_in <= v;
      1: supply_overvoltage <= v;
      2: logic_supply_por_fall <= v;
      default: pump_low_in <= v;
    endcase
    tick(6);
  endtask

  // hang guard
  initial begin
    repeat (80000) @(posedge core_clk);
    errors++;
    summarize();
  end

  // count one-cycle frame strobes
  always @(posedge core_clk) begin
    if (frame_strobe === 1'b1) strobes <= strobes + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    errors = 0;
    check_count = 0;
    sys_rst = 1'b1;
    logic_supply_por_fall = 1'b0;
    pump_fail_in = 1'b0;
    pump_low_in = 1'b0;
    supply_overvoltage = 1'b0;
    reply_data = 11'h5A5;
    do_reset();
    cmp1("driver_power_enable", 1'b0, driver_power_enable);
    cmp1("pump_enable", 1'b0, pump_enable);
    cmp1("gate_enable", 1'b0, gate_enable);
    cmp1("switched_pump_output", 1'b0, switched_pump_output);
    cmp1("watchdog_period_select", 1'b0, watchdog_period_select);
    cmp1("spi_dout_oe_n", 1'b1, spi_dout_oe_n);
    cmp1("spi_error_flag", 1'b0, spi_error_flag);
    cmp1("normal_mode_flag", 1'b1, normal_mode_flag);
    send(32'h1003, 16);
    cmp1("driver_power_enable", 1'b1, driver_power_enable);
    cmp1("pump_enable", 1'b1, pump_enable);
    cmp1("switched_pump_output", 1'b1, switched_pump_output);
    cmp1("gate_enable", 1'b1, gate_enable);
    cmp16("frame_strobe_count", 16'h0001, strobes[15:0]);
    send(32'h1805, 16);
    cmp16("reply", 16'h15A5, rx[15:0]);
    cmp16("frame_word", 16'h1805, frame_word);
    cmp1("switched_pump_output", 1'b0, switched_pump_output);
    cmp1("watchdog_period_select", 1'b1, watchdog_period_select);
    cmp1("spi_dout_oe_n", 1'b1, spi_dout_oe_n);
    send(32'hC3A51001, 32);
    cmp16("chain_reply", 16'h1DA5, rx[31:16]);
    cmp16("chain_pass", 16'hC3A5, rx[15:0]);
    cmp1("watchdog_period_select", 1'b0, watchdog_period_select);
    cmp1("spi_error_flag", 1'b0, spi_error_flag);
    pin(0, 1'b1);
    cmp1("pump_fail_flag", 1'b1, pump_fail_flag);
    cmp1("status_pump_fail", 1'b1, main_status_reg[swpc_pkg::ST_CPF_POS]);
    cmp1("gate_enable", 1'b0, gate_enable);
    pin(0, 1'b0);
    cmp1("gate_enable", 1'b1, gate_enable);
    pin(1, 1'b1);
    cmp1("pump_enable", 1'b0, pump_enable);
    pin(1, 1'b0);
    cmp1("pump_enable", 1'b1, pump_enable);
    pin(3, 1'b1);
    cmp1("pump_low_flag", 1'b1, pump_low_flag);
    cmp1("status_pump_low", 1'b1, main_status_reg[swpc_pkg::ST_CPL_POS]);
    cmp1("gate_enable", 1'b1, gate_enable);
    pin(3, 1'b0);
    cmp1("pump_low_flag", 1'b0, pump_low_flag);
    pin(2, 1'b1);
    cmp1("driver_power_enable", 1'b0, driver_power_enable);
    cmp1("normal_mode_flag", 1'b0, normal_mode_flag);
    send(32'h1803, 16);
    pin(2, 1'b0);
    cmp1("driver_power_enable", 1'b0, driver_power_enable);
    cmp1("switched_pump_output", 1'b0, switched_pump_output);
    cmp16("frame_strobe_count", 16'h0003, strobes[15:0]);
    // each kind of spi error forces failsafe
    for (int k = 0; k < 7; k++) begin
      do_reset();
      if (k != 6) send(32'h1001, 16);
      case (k)
        0: send(32'h1801, 15);
        1: send(32'h0000, 0);
        2: send(32'hB800, 16);
        3: send(32'h1809, 16);
        4: send(32'h0000, 16);
        5: tick(2100);
        default: send(32'h1801, 16);
      endcase
      cmp1("spi_error_flag", 1'b1, spi_error_flag);
      cmp1("error_cause", 1'b1, main_status_reg[cause_of(k)]);
      cmp1("status_normal", 1'b0, main_status_reg[swpc_pkg::ST_NM_POS]);
      cmp1("driver_power_enable", 1'b0, driver_power_enable);
      cmp1("normal_mode_flag", 1'b0, normal_mode_flag);
    end
    // long watchdog period
    do_reset();
    send(32'h1005, 16);
    tick(2100);
    cmp1("spi_error_flag", 1'b0, spi_error_flag);
    tick(2100);
    cmp1("timeout", 1'b1, main_status_reg[swpc_pkg::ST_TMO_POS]);
    summarize();
  end
endmodule
